// >>> core/pmwc_pkg.sv
package pmwc_pkg;

    // ==================================================
    // Register map (byte addresses, one word each).
    // ==================================================
    localparam logic [3:0] power_control_reg_addr = 4'h0;
    localparam logic [3:0] power_unit_config_reg_addr = 4'h4;
    localparam logic [3:0] power_unit_mode_reg_addr = 4'h8;
    localparam logic [3:0] status_reg_addr = 4'hc;

    // ==================================================
    // Field positions.
    // ==================================================
    localparam int ctl_idle_bit = 0;
    localparam int ctl_stop_bit = 1;
    localparam int cfg_cmp_bit = 0;
    localparam int cfg_pmat_bit = 1;
    localparam int cfg_alarm_bit = 2;
    localparam int cfg_oscfail_bit = 3;
    localparam int cfg_pinrst_bit = 4;
    localparam int cfg_clear_bit = 5;
    localparam int cfg_suspend_bit = 6;
    localparam int cfg_sleep_bit = 7;
    localparam int mode_wakeoe_bit = 6;
    localparam int mode_battery_monitor_disable_bit = 5;

    // ==================================================
    // Reset values and timing.
    // ==================================================
    localparam logic [7:0] ctl_reset = 8'h00;
    localparam logic [7:0] mode_reset = 8'h00;
    localparam logic [31:0] reset_vector = 32'h0000_0000;
    localparam int flag_blank_cycles = 2;
    localparam int clk_mhz = 100;
    localparam int pin_wake_hold_us = 15;
    localparam int pin_wake_hold_cycles = pin_wake_hold_us * clk_mhz;

    typedef enum logic [5:0] {
        pmwc_run = 6'h01,
        pmwc_idle = 6'h02,
        pmwc_stop = 6'h04,
        pmwc_suspend = 6'h08,
        pmwc_sleep = 6'h10,
        pmwc_resume = 6'h20
    } pmwc_state_t;

    typedef struct packed {
        logic osc_fail;
        logic alarm;
        logic port_match;
        logic cmp_rise;
    } pmwc_wake_t;

    typedef struct packed {
        logic cpu_halt;
        logic precision_osc_en;
        logic all_osc_en;
        logic sys_clk_en;
        logic core_reg_en;
        logic ram_on_battery;
        logic io_hold;
    } pmwc_power_t;

endpackage

// >>> core/pmwc_reset_sync.sv
`timescale 1ns/1ps
// Three-stage edge detector for the reset pin; one-cycle pulse on falling edge.
module pmwc_pin_edge
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pin_n,
    output logic fall_pulse
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
            fall_pulse <= 1'b0;
        end
        else
        begin
            s1_ff <= pin_n;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            fall_pulse <= s3_ff & ~s2_ff;
        end
    end

endmodule

// >>> core/pmwc_top.sv
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pmwc_top
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic watchdog_expire,
    input wire logic missing_clock_timeout,
    input wire logic ext_reset,
    input wire logic reset_pin_n,
    input wire logic two_cell_mode,
    input wire pmwc_pkg::pmwc_wake_t wake_events,
    output pmwc_pkg::pmwc_power_t power_ctl,
    output logic internal_reset,
    output logic por_request,
    output logic [31:0] fetch_addr,
    output logic fetch_addr_load,
    output logic wake_request,
    output logic battery_monitor_en
);

    pmwc_pkg::pmwc_state_t state_ff;
    pmwc_pkg::pmwc_state_t nxt_state;
    logic [7:0] ctl_ff;
    logic [7:0] mode_ff;
    logic [3:0] wake_en_ff;
    logic [4:0] flags_ff;
    logic [1:0] blank_ff;
    logic pin_fall;
    logic ack_ff;
    logic [3:0] ev;
    logic wake_hit;
    logic any_reset;
    logic wr_cfg;
    logic enter_suspend;
    logic enter_sleep;
    logic refuse;

    // ==================================================
    // Reset-pin edge detection.
    // ==================================================
    pmwc_pin_edge u_edge
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_n(reset_pin_n),
        .fall_pulse(pin_fall)
    );

    function automatic logic [31:0] pmwc_read_word(input logic [7:0] v);
        pmwc_read_word = {24'h000000, v};
    endfunction

    assign ev = {wake_events.osc_fail, wake_events.alarm,
                 wake_events.port_match, wake_events.cmp_rise};
    assign any_reset = ext_reset | watchdog_expire | missing_clock_timeout;
    assign wr_cfg = avs_write & ack_ff & (avs_address == pmwc_pkg::power_unit_config_reg_addr)
                    & avs_byteenable[0];
    assign enter_sleep = wr_cfg & avs_writedata[pmwc_pkg::cfg_sleep_bit];
    assign enter_suspend = wr_cfg & avs_writedata[pmwc_pkg::cfg_suspend_bit]
                           & ~avs_writedata[pmwc_pkg::cfg_sleep_bit];
    // Refusal checks flags against the enables carried by the entry write.
    assign refuse = |(flags_ff[3:0] & avs_writedata[3:0]);

    // Comparator wake only counts in sleep when the supply is two-cell.
    always_comb
    begin
        wake_hit = |(ev[3:1] & wake_en_ff[3:1]) | pin_fall;
        if (ev[0] & wake_en_ff[0])
        begin
            if (state_ff != pmwc_pkg::pmwc_sleep || two_cell_mode)
            begin
                wake_hit = 1'b1;
            end
        end
    end

    // ==================================================
    // Avalon slave: one wait cycle, then acknowledge.
    // ==================================================
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_ff);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end
        else if ((avs_read | avs_write) & ~ack_ff)
        begin
            avs_response <= 2'h0;
            avs_readdata <= 32'h0000_0000;
            case (avs_address)
                pmwc_pkg::power_control_reg_addr:
                    avs_readdata <= pmwc_read_word(ctl_ff);
                pmwc_pkg::power_unit_config_reg_addr:
                    avs_readdata <= (blank_ff != 2'h0) ? 32'h0000_0000
                                    : pmwc_read_word({3'h0, flags_ff});
                pmwc_pkg::power_unit_mode_reg_addr:
                    avs_readdata <= pmwc_read_word({mode_ff[7:5], 5'h00});
                pmwc_pkg::status_reg_addr:
                    avs_readdata <= {26'h0, state_ff};
                default:
                    avs_response <= 2'h2;
            endcase
        end
    end

    // ==================================================
    // Control and mode registers.
    // ==================================================
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl_ff <= pmwc_pkg::ctl_reset;
        end
        else if (any_reset)
        begin
            ctl_ff <= pmwc_pkg::ctl_reset;
        end
        else if (avs_write & ack_ff & avs_byteenable[0]
                 & (avs_address == pmwc_pkg::power_control_reg_addr))
        begin
            ctl_ff <= avs_writedata[7:0];
        end
        else if (state_ff == pmwc_pkg::pmwc_idle && irq_pending)
        begin
            ctl_ff[pmwc_pkg::ctl_idle_bit] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_ff <= pmwc_pkg::mode_reset;
        end
        else if (any_reset)
        begin
            mode_ff[pmwc_pkg::mode_battery_monitor_disable_bit] <= 1'b0;
        end
        else if (avs_write & ack_ff & avs_byteenable[0]
                 & (avs_address == pmwc_pkg::power_unit_mode_reg_addr))
        begin
            mode_ff <= {avs_writedata[7:5], 5'h00};
        end
    end

    // ==================================================
    // Wake enables and flags.
    // ==================================================
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wake_en_ff <= 4'h0;
        end
        else if (wr_cfg)
        begin
            wake_en_ff <= avs_writedata[3:0];
        end
    end

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags_ff <= 5'h00;
        end
        else
        begin
            flags_ff <= ((wr_cfg & avs_writedata[pmwc_pkg::cfg_clear_bit]) ? 5'h00
                         : flags_ff) | {pin_fall, ev};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blank_ff <= 2'h0;
        end
        else if (state_ff == pmwc_pkg::pmwc_suspend && wake_hit)
        begin
            blank_ff <= 2'(pmwc_pkg::flag_blank_cycles);
        end
        else if (blank_ff != 2'h0)
        begin
            blank_ff <= blank_ff - 2'h1;
        end
    end

    // ==================================================
    // Power mode sequencer.
    // ==================================================
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            pmwc_pkg::pmwc_run:
            begin
                if (enter_sleep & ~refuse)
                    nxt_state = pmwc_pkg::pmwc_sleep;
                else if (enter_suspend & ~refuse)
                    nxt_state = pmwc_pkg::pmwc_suspend;
                else if (instr_done & ctl_ff[pmwc_pkg::ctl_stop_bit])
                    nxt_state = pmwc_pkg::pmwc_stop;
                else if (instr_done & ctl_ff[pmwc_pkg::ctl_idle_bit])
                    nxt_state = pmwc_pkg::pmwc_idle;
            end
            pmwc_pkg::pmwc_idle:
                if (irq_pending)
                    nxt_state = pmwc_pkg::pmwc_run;
            pmwc_pkg::pmwc_stop:
                nxt_state = pmwc_pkg::pmwc_stop;
            pmwc_pkg::pmwc_suspend,
            pmwc_pkg::pmwc_sleep:
                if (wake_hit)
                    nxt_state = pmwc_pkg::pmwc_resume;
            pmwc_pkg::pmwc_resume:
                nxt_state = pmwc_pkg::pmwc_run;
            default:
                nxt_state = pmwc_pkg::pmwc_run;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= pmwc_pkg::pmwc_run;
        end
        else if (any_reset)
        begin
            state_ff <= pmwc_pkg::pmwc_run;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==================================================
    // Power controls and reset outputs.
    // ==================================================
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            power_ctl <= '{cpu_halt: 1'b0, precision_osc_en: 1'b1, all_osc_en: 1'b1,
                           sys_clk_en: 1'b1, core_reg_en: 1'b1, ram_on_battery: 1'b0,
                           io_hold: 1'b0};
        end
        else
        begin
            // Peripherals and registers are untouched in idle; only the CPU halts.
            power_ctl.cpu_halt <= (nxt_state != pmwc_pkg::pmwc_run) & ~any_reset;
            power_ctl.precision_osc_en <= ~(nxt_state inside {pmwc_pkg::pmwc_stop,
                pmwc_pkg::pmwc_suspend, pmwc_pkg::pmwc_sleep}) | any_reset;
            power_ctl.all_osc_en <= ~(nxt_state inside {pmwc_pkg::pmwc_suspend,
                pmwc_pkg::pmwc_sleep}) | any_reset;
            power_ctl.sys_clk_en <= ~(nxt_state inside {pmwc_pkg::pmwc_suspend,
                pmwc_pkg::pmwc_sleep}) | any_reset;
            power_ctl.core_reg_en <= (nxt_state != pmwc_pkg::pmwc_sleep) | any_reset;
            power_ctl.ram_on_battery <= (nxt_state == pmwc_pkg::pmwc_sleep) & ~any_reset;
            power_ctl.io_hold <= (nxt_state == pmwc_pkg::pmwc_sleep) & ~any_reset;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            internal_reset <= 1'b0;
            por_request <= 1'b0;
            fetch_addr <= pmwc_pkg::reset_vector;
            fetch_addr_load <= 1'b0;
        end
        else
        begin
            internal_reset <= (watchdog_expire | missing_clock_timeout)
                              & (state_ff != pmwc_pkg::pmwc_suspend)
                              & (state_ff != pmwc_pkg::pmwc_sleep);
            por_request <= any_reset & mode_ff[pmwc_pkg::mode_battery_monitor_disable_bit];
            fetch_addr <= pmwc_pkg::reset_vector;
            fetch_addr_load <= any_reset;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wake_request <= 1'b0;
            battery_monitor_en <= 1'b1;
        end
        else
        begin
            wake_request <= mode_ff[pmwc_pkg::mode_wakeoe_bit]
                            & (nxt_state != pmwc_pkg::pmwc_sleep);
            battery_monitor_en <= ~mode_ff[pmwc_pkg::mode_battery_monitor_disable_bit];
        end
    end

endmodule

// >>> sim/pmwc_top_sva.sv
`timescale 1ns/1ps
module pmwc_chk
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire pmwc_pkg::pmwc_power_t power_ctl,
    input wire logic internal_reset,
    input wire logic por_request,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_addr_load,
    input wire logic wake_request,
    input wire logic battery_monitor_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ==================================================
    // Bus handshake and power sequencing.
    // ==================================================
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_ack_once: assert property (s_req |=> s_ack)
        else $error("bus answer is not a single ack cycle");
    chk_unmapped_resp: assert property (s_req ##0 (avs_address[1:0] != 2'h0)
        |=> avs_response == 2'h2)
        else $error("unmapped access without error response");
    chk_fetch_vector: assert property (fetch_addr_load |-> fetch_addr == 32'h0000_0000)
        else $error("fetch address not zero on load");
    chk_reset_fetch: assert property (internal_reset |-> ##[0:2] fetch_addr_load)
        else $error("internal reset without fetch restart");
    chk_sleep_retain: assert property (!power_ctl.core_reg_en
        |-> power_ctl.ram_on_battery && power_ctl.io_hold)
        else $error("sleep without battery ram and pin hold");
    chk_sleep_wake_low: assert property (!power_ctl.core_reg_en
        && !$past(power_ctl.core_reg_en) |-> !wake_request)
        else $error("wake request high while asleep");
    chk_suspend_osc_off: assert property (!power_ctl.sys_clk_en
        |-> !power_ctl.all_osc_en && power_ctl.cpu_halt)
        else $error("clock gated with oscillators running");
    chk_stop_cpu_halt: assert property (!power_ctl.precision_osc_en |-> power_ctl.cpu_halt)
        else $error("precision oscillator off with cpu running");
    chk_por_monitor: assert property (por_request |-> ##[0:2] battery_monitor_en)
        else $error("power-on reset did not re-enable monitor");
endmodule

bind pmwc_top pmwc_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .power_ctl(power_ctl), .internal_reset(internal_reset),
    .por_request(por_request), .fetch_addr(fetch_addr), .fetch_addr_load(fetch_addr_load),
    .wake_request(wake_request), .battery_monitor_en(battery_monitor_en));

// >>> sim/power_mode_wake_controller_tb.sv
`timescale 1ns/1ps
module power_mode_wake_controller_tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic instr_done = 1'b0;
    logic irq_pending = 1'b0;
    logic watchdog_expire = 1'b0;
    logic missing_clock_timeout = 1'b0;
    logic ext_reset = 1'b0;
    logic reset_pin_n = 1'b1;
    logic two_cell_mode = 1'b1;
    logic [3:0] wev = 4'h0;
    pmwc_pkg::pmwc_power_t power_ctl;
    logic internal_reset;
    logic por_request;
    logic [31:0] fetch_addr;
    logic fetch_addr_load;
    logic wake_request;
    logic battery_monitor_en;
    int err_total = 0;
    int n_compared = 0;
    logic [31:0] q;
    logic [2:0] s;
    localparam int b_clk = 3;
    localparam int b_core = 2;

    pmwc_top dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .instr_done(instr_done), .irq_pending(irq_pending),
        .watchdog_expire(watchdog_expire), .missing_clock_timeout(missing_clock_timeout),
        .ext_reset(ext_reset), .reset_pin_n(reset_pin_n), .two_cell_mode(two_cell_mode),
        .wake_events(pmwc_pkg::pmwc_wake_t'(wev)), .power_ctl(power_ctl),
        .internal_reset(internal_reset), .por_request(por_request), .fetch_addr(fetch_addr),
        .fetch_addr_load(fetch_addr_load), .wake_request(wake_request),
        .battery_monitor_en(battery_monitor_en));

    always #5 sys_clk = ~sys_clk;

    // ==================================================
    // Shared tasks.
    // ==================================================
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge.
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
        output logic [31:0] rq, output logic [1:0] rr);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rq = avs_readdata;
        rr = avs_response;
        check("bus answer", {31'h0, avs_waitrequest}, 32'h0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] dq;
        logic [1:0] dr;
        xfer(1'b1, a, d, dq, dr);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] rq);
        logic [1:0] dr;
        xfer(1'b0, a, 8'h00, rq, dr);
    endtask

    task automatic wait_state(input logic [5:0] exp);
        logic [31:0] v;
        int n;
        n = 0;
        rd(pmwc_pkg::status_reg_addr, v);
        while (v[5:0] !== exp && n < 10)
        begin
            rd(pmwc_pkg::status_reg_addr, v);
            n++;
        end
        check("state", v, {26'h0, exp});
    endtask

    task automatic wait_pc(input int b, input logic v);
        int n;
        n = 0;
        while (power_ctl[b] !== v && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("power_ctl bit", {31'h0, power_ctl[b]}, {31'h0, v});
        @(posedge sys_clk);
    endtask

    // Collects internal reset, fetch load and power-on request over eight cycles.
    task automatic saw(output logic [2:0] r);
        r = 3'h0;
        repeat (8)
        begin
            @(negedge sys_clk);
            r = r | {internal_reset, fetch_addr_load, por_request};
        end
    endtask

    task automatic enter_cpu_mode(input logic [7:0] d);
        wr(pmwc_pkg::power_control_reg_addr, d);
        instr_done <= 1'b1;
        @(posedge sys_clk);
        instr_done <= 1'b0;
    endtask

    // ==================================================
    // Scenarios.
    // ==================================================
    task automatic t_reset;
        logic [1:0] r;
        check("power_ctl", power_ctl, 7'h3c);
        check("monitor", battery_monitor_en, 1'b1);
        check("wake out", wake_request, 1'b0);
        rd(pmwc_pkg::power_unit_mode_reg_addr, q);
        check("mode reg", q, 32'h0);
        wait_state(6'h01);
        xfer(1'b0, 4'h2, 8'h00, q, r);
        check("unmapped resp", r, 2'h2);
        check("unmapped data", q, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_idle;
        enter_cpu_mode(8'hf1);
        wait_state(6'h02);
        check("cpu halt", power_ctl.cpu_halt, 1'b1);
        check("precision osc", power_ctl.precision_osc_en, 1'b1);
        irq_pending <= 1'b1;
        wait_state(6'h01);
        irq_pending <= 1'b0;
        rd(pmwc_pkg::power_control_reg_addr, q);
        check("control after idle", q, 32'hf0);
        $display("test idle done");
    endtask

    task automatic t_reset_exit(input logic stop);
        enter_cpu_mode(stop ? 8'h02 : 8'h01);
        wait_state(stop ? 6'h04 : 6'h02);
        if (stop)
        begin
            check("stop osc", {power_ctl.precision_osc_en, power_ctl.all_osc_en}, 2'b01);
            irq_pending <= 1'b1;
            repeat (5) @(posedge sys_clk);
            irq_pending <= 1'b0;
            wait_state(6'h04);
        end
        watchdog_expire <= !stop;
        missing_clock_timeout <= stop;
        @(posedge sys_clk);
        watchdog_expire <= 1'b0;
        missing_clock_timeout <= 1'b0;
        saw(s);
        check("reset pulses", s, 3'b110);
        check("fetch vector", fetch_addr, 32'h0);
        wait_state(6'h01);
        rd(pmwc_pkg::power_control_reg_addr, q);
        check("control after reset", q, 32'h0);
        $display("test reset exit done");
    endtask

    task automatic t_sources;
        for (int i = 0; i < 4; i++)
        begin
            // The bench clock stands for the oscillator picked before entry.
            wr(pmwc_pkg::power_unit_config_reg_addr, 8'h40 | (8'h01 << i));
            wait_pc(b_clk, 1'b0);
            wev <= 4'h1 << ((i + 1) % 4);
            @(posedge sys_clk);
            wev <= 4'h0;
            repeat (6) @(posedge sys_clk);
            check("still suspended", power_ctl.sys_clk_en, 1'b0);
            wev <= 4'h1 << i;
            @(posedge sys_clk);
            wev <= 4'h0;
            rd(pmwc_pkg::power_unit_config_reg_addr, q);
            check("flags blanked", q, 32'h0);
            wait_pc(b_clk, 1'b1);
            check("osc restored", power_ctl.all_osc_en, 1'b1);
            wait_state(6'h01);
            rd(pmwc_pkg::power_unit_config_reg_addr, q);
            check("flags after wake", q, (8'h01 << i) | (8'h01 << ((i + 1) % 4)));
            wr(pmwc_pkg::power_unit_config_reg_addr, 8'h20);
        end
        $display("test wake sources done");
    endtask

    task automatic t_refuse;
        wev <= 4'h4;
        @(posedge sys_clk);
        wev <= 4'h0;
        repeat (3) @(posedge sys_clk);
        rd(pmwc_pkg::power_unit_config_reg_addr, q);
        check("flag while running", q, 32'h04);
        wr(pmwc_pkg::power_unit_config_reg_addr, 8'h44);
        repeat (3) @(posedge sys_clk);
        check("entry refused", power_ctl.sys_clk_en, 1'b1);
        wait_state(6'h01);
        wr(pmwc_pkg::power_unit_config_reg_addr, 8'h20);
        rd(pmwc_pkg::power_unit_config_reg_addr, q);
        check("flags cleared", q, 32'h0);
        $display("test refuse done");
    endtask

    task automatic t_sleep;
        two_cell_mode <= 1'b0;
        wr(pmwc_pkg::power_unit_mode_reg_addr, 8'h40);
        repeat (2) @(posedge sys_clk);
        check("wake out awake", wake_request, 1'b1);
        wr(pmwc_pkg::power_unit_config_reg_addr, 8'h81);
        wait_pc(b_core, 1'b0);
        repeat (2) @(posedge sys_clk);
        check("ram hold", {power_ctl.ram_on_battery, power_ctl.io_hold}, 2'b11);
        check("wake out asleep", wake_request, 1'b0);
        wev <= 4'h1;
        @(posedge sys_clk);
        wev <= 4'h0;
        repeat (8) @(posedge sys_clk);
        check("cmp ignored", power_ctl.core_reg_en, 1'b0);
        reset_pin_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        wait_pc(b_core, 1'b1);
        repeat (2) @(posedge sys_clk);
        check("wake out raised", wake_request, 1'b1);
        wait_state(6'h01);
        rd(pmwc_pkg::power_unit_config_reg_addr, q);
        check("pin wake flag", q[4], 1'b1);
        wr(pmwc_pkg::power_unit_config_reg_addr, 8'h20);
        two_cell_mode <= 1'b1;
        $display("test sleep done");
    endtask

    task automatic t_monitor;
        wr(pmwc_pkg::power_unit_mode_reg_addr, 8'h20);
        repeat (2) @(posedge sys_clk);
        check("monitor off", battery_monitor_en, 1'b0);
        ext_reset <= 1'b1;
        @(posedge sys_clk);
        ext_reset <= 1'b0;
        saw(s);
        check("por and fetch", s, 3'b011);
        check("monitor on", battery_monitor_en, 1'b1);
        $display("test monitor done");
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_idle();
        t_reset_exit(1'b0);
        t_reset_exit(1'b1);
        t_sources();
        t_refuse();
        t_sleep();
        t_monitor();
        final_report();
    end

    initial
    begin
        #400000;
        err_total++;
        final_report();
    end
endmodule
